//--- include/ccu_pkg.sv
package ccu_pkg;
	// register word byte addresses
	localparam logic [7:0] REG_CONTROL   = 8'h00;
	localparam logic [7:0] REG_VALUE_LOW = 8'h04;
	localparam logic [7:0] REG_VALUE_HIGH= 8'h08;
	localparam logic [7:0] REG_FLAGS     = 8'h0c;
	localparam logic [7:0] REG_TIMEBASE  = 8'h10;
	localparam logic [7:0] REG_TB_CTRL   = 8'h14;

	// control field layout
	localparam int MODE_LSB = 0;
	localparam int MODE_MSB = 3;
	localparam int DUTY_LSB = 4;
	localparam int DUTY_MSB = 5;

	// reset values
	localparam logic [7:0]  CONTROL_RST  = 8'h00;
	localparam logic [15:0] VALUE_RST    = 16'h0000;
	localparam logic [15:0] TIMEBASE_RST = 16'h0000;

	// flag register bit positions
	localparam int FLAG_EVENT    = 0;
	localparam int FLAG_OVERFLOW = 1;

	// timebase control bit positions
	localparam int TB_RUN  = 0;
	localparam int TB_ADON = 1;

	// capture prescale counts
	localparam logic [3:0] PRESC_4  = 4'h3;
	localparam logic [3:0] PRESC_16 = 4'hf;

	// mode encodings
	localparam logic [3:0] MODE_OFF      = 4'h0;
	localparam logic [3:0] MODE_CAP_FALL = 4'h4;
	localparam logic [3:0] MODE_CAP_RISE = 4'h5;
	localparam logic [3:0] MODE_CAP_R4   = 4'h6;
	localparam logic [3:0] MODE_CAP_R16  = 4'h7;
	localparam logic [3:0] MODE_CMP_SET  = 4'h8;
	localparam logic [3:0] MODE_CMP_CLR  = 4'h9;
	localparam logic [3:0] MODE_CMP_SW   = 4'ha;
	localparam logic [3:0] MODE_CMP_SPEC = 4'hb;

	typedef enum logic [1:0] {
		CCU_ST_IDLE,
		CCU_ST_CAPTURE,
		CCU_ST_COMPARE,
		CCU_ST_PULSE
	} ccu_class_e;
endpackage

//--- core/ccu_sync.sv
`timescale 1ns/1ns
module ccu_sync (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic async_i,
	output logic      sync_o
);
	logic stage1;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stage1 <= 1'b0;
			sync_o <= 1'b0;
		end else begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end
endmodule

//--- core/ccu_top.sv
`timescale 1ns/1ns
// Operation
// - mode zero turns unit off and resets state; 0001-0011 do nothing
// - modes 0100-0111 capture on fall, rise, 4th rise, 16th rise
// - mode 1000 drives output high on match and sets event flag
// - mode 1001 drives output low on match and sets event flag
// - mode 1010 only sets flag on match; pin left to the port
// - mode 1011 sets flag, resets timebase, starts conversion if enabled
// - 110x pulse-width active high, 111x active low, bit 0 ignored
// - control bits 5-4 are duty low bits, used in pulse mode only
// - control bits 7-6 unimplemented and read as zero
// - capture copies full 16-bit timebase into value registers
// - every capture sets event flag; only software clears it
// - new capture overwrites value; no overrun indication
// - capture samples the pin level even when driven as output
// - prescaler cleared when off, not in capture, or on reset
// - switching prescale keeps counter; software writes zero first
// - compare mode constantly compares value with timebase counter
// - special event at once; timebase reset on next timer tick
// - writing zero to control forces compare latch low
// - special event reset does not set timebase overflow flag
module ccu_top
	import ccu_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	input  wire logic        event_pin_i,
	input  wire logic        port_data_i,
	input  wire logic        pin_direction_bit_i,
	input  wire logic        pulse_tick_i,
	output logic             event_pin_o,
	output logic             event_pin_oe_o,
	output logic             unit_event_flag_o,
	output logic             special_event_o,
	output logic             adc_start_o
);
	// ------------------------------------------------------------
	// registers and state
	// ------------------------------------------------------------
	logic [7:0]  unit_control;
	logic [15:0] capture_compare_value;
	logic [15:0] timebase_counter;
	logic        unit_event_flag;
	logic        timebase_overflow_flag;
	logic        tb_run;
	logic        adc_enable;
	logic        cmp_latch;
	logic [3:0]  presc_cnt;
	logic        pin_sync;
	logic        pin_prev;
	logic [7:0]  duty_shadow;
	logic [1:0]  duty_low_latch;
	logic [9:0]  pulse_count;
	logic        pulse_level;

	logic [3:0]  unit_mode_select;
	logic [1:0]  duty_low_bits;
	ccu_class_e  mode_class;
	logic        bus_req;
	logic        wr_req;
	logic        rise;
	logic        fall;
	logic        capture_evt;
	logic        match;
	logic        match_evt;
	logic        ctrl_wr;

	assign unit_mode_select = unit_control[MODE_MSB:MODE_LSB];
	assign duty_low_bits    = unit_control[DUTY_MSB:DUTY_LSB];

	always_comb begin
		unique casez (unit_mode_select)
			4'b01??: mode_class = CCU_ST_CAPTURE;
			4'b10??: mode_class = CCU_ST_COMPARE;
			4'b11??: mode_class = CCU_ST_PULSE;
			default: mode_class = CCU_ST_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// wishbone slave, one wait state
	// ------------------------------------------------------------
	assign bus_req = cyc_i && stb_i && !ack_o;
	assign wr_req  = bus_req && we_i && sel_i[0];
	assign ctrl_wr = wr_req && adr_i == REG_CONTROL;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			ack_o <= 1'b0;
		else
			ack_o <= bus_req;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (bus_req && !we_i) begin
			unique case (adr_i)
				REG_CONTROL:    dat_o <= {26'h0, unit_control[5:0]};
				REG_VALUE_LOW:  dat_o <= {24'h0, capture_compare_value[7:0]};
				REG_VALUE_HIGH: dat_o <= {24'h0, capture_compare_value[15:8]};
				REG_FLAGS:      dat_o <= {30'h0, timebase_overflow_flag,
					unit_event_flag};
				REG_TIMEBASE:   dat_o <= {16'h0, timebase_counter};
				REG_TB_CTRL:    dat_o <= {30'h0, adc_enable, tb_run};
				default:        dat_o <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			unit_control <= CONTROL_RST;
		else if (ctrl_wr)
			unit_control <= {2'b00, dat_i[5:0]};
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tb_run     <= 1'b0;
			adc_enable <= 1'b0;
		end else if (wr_req && adr_i == REG_TB_CTRL) begin
			tb_run     <= dat_i[TB_RUN];
			adc_enable <= dat_i[TB_ADON];
		end
	end

	// ------------------------------------------------------------
	// event pin edge detection
	// ------------------------------------------------------------
	ccu_sync u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i (event_pin_i),
		.sync_o  (pin_sync)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i)
			pin_prev <= 1'b0;
		else
			pin_prev <= pin_sync;
	end

	assign rise = pin_sync && !pin_prev;
	assign fall = !pin_sync && pin_prev;

	// ------------------------------------------------------------
	// capture prescaler
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i || mode_class != CCU_ST_CAPTURE)
			presc_cnt <= 4'h0;
		else if (rise)
			presc_cnt <= presc_cnt + 4'h1;
	end

	always_comb begin
		unique case (unit_mode_select)
			MODE_CAP_FALL: capture_evt = fall;
			MODE_CAP_RISE: capture_evt = rise;
			MODE_CAP_R4:   capture_evt = rise && presc_cnt[1:0] == PRESC_4[1:0];
			MODE_CAP_R16:  capture_evt = rise && presc_cnt == PRESC_16;
			default:       capture_evt = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// compare
	// ------------------------------------------------------------
	assign match = mode_class == CCU_ST_COMPARE
		&& capture_compare_value == timebase_counter;

	// one event per match episode
	logic match_prev;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			match_prev <= 1'b0;
		else
			match_prev <= match;
	end
	assign match_evt = match && !match_prev;

	assign special_event_o = match && unit_mode_select == MODE_CMP_SPEC;
	assign adc_start_o     = special_event_o && adc_enable && !match_prev;

	// ------------------------------------------------------------
	// timebase counter
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timebase_counter       <= TIMEBASE_RST;
			timebase_overflow_flag <= 1'b0;
		end else begin
			if (wr_req && adr_i == REG_TIMEBASE)
				timebase_counter <= dat_i[15:0];
			else if (tb_run && pulse_tick_i) begin
				// special reset leaves the overflow flag alone
				// reset on the first tick that still sees the match
				if (special_event_o)
					timebase_counter <= TIMEBASE_RST;
				else
					timebase_counter <= timebase_counter + 16'h0001;
			end
			if (tb_run && pulse_tick_i && !special_event_o
				&& timebase_counter == 16'hffff)
				timebase_overflow_flag <= 1'b1;
			else if (wr_req && adr_i == REG_FLAGS && dat_i[FLAG_OVERFLOW])
				timebase_overflow_flag <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// value register pair
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i)
			capture_compare_value <= VALUE_RST;
		else if (capture_evt)
			capture_compare_value <= timebase_counter;
		else if (wr_req && adr_i == REG_VALUE_LOW)
			capture_compare_value[7:0] <= dat_i[7:0];
		else if (wr_req && adr_i == REG_VALUE_HIGH
			&& mode_class != CCU_ST_PULSE)
			capture_compare_value[15:8] <= dat_i[7:0];
	end

	// ------------------------------------------------------------
	// event flag, set wins over clear (write one to clear)
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i)
			unit_event_flag <= 1'b0;
		else if (capture_evt || match_evt)
			unit_event_flag <= 1'b1;
		else if (wr_req && adr_i == REG_FLAGS && dat_i[FLAG_EVENT])
			unit_event_flag <= 1'b0;
	end
	assign unit_event_flag_o = unit_event_flag;

	// ------------------------------------------------------------
	// compare output latch
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i || unit_mode_select == MODE_OFF)
			cmp_latch <= 1'b0;
		else if (match_evt && unit_mode_select == MODE_CMP_SET)
			cmp_latch <= 1'b1;
		else if (match_evt && unit_mode_select == MODE_CMP_CLR)
			cmp_latch <= 1'b0;
	end

	// ------------------------------------------------------------
	// pulse-width generator on the pulse timebase ticks
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i || mode_class != CCU_ST_PULSE) begin
			pulse_count    <= 10'h000;
			duty_shadow    <= 8'h00;
			duty_low_latch <= 2'b00;
			pulse_level    <= 1'b0;
		end else if (pulse_tick_i) begin
			pulse_count <= pulse_count + 10'h001;
			if (pulse_count == 10'h3ff) begin
				duty_shadow    <= capture_compare_value[7:0];
				duty_low_latch <= duty_low_bits;
				pulse_level    <= {capture_compare_value[7:0],
					duty_low_bits} != 10'h000;
			end else if (pulse_count + 10'h001
				== {duty_shadow, duty_low_latch})
				pulse_level <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// pin driver
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			event_pin_o    <= 1'b0;
			event_pin_oe_o <= 1'b0;
		end else begin
			event_pin_oe_o <= !pin_direction_bit_i;
			unique case (1'b1)
				unit_mode_select == MODE_CMP_SET,
				unit_mode_select == MODE_CMP_CLR:
					event_pin_o <= cmp_latch;
				mode_class == CCU_ST_PULSE:
					event_pin_o <= pulse_level ^ unit_mode_select[1];
				default:
					event_pin_o <= port_data_i;
			endcase
		end
	end
endmodule

//--- dv/ccu_monitor.sv
`timescale 1ns/1ns
module ccu_monitor
	import ccu_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        event_pin_i,
	input wire logic        port_data_i,
	input wire logic        event_pin_o,
	input wire logic        unit_event_flag_o,
	input wire logic        special_event_o,
	input wire logic        adc_start_o
);
	logic [3:0] mode;
	logic       take;
	// write taken at the same edge as the slave takes it
	assign take = cyc_i && stb_i && !ack_o && we_i && sel_i[0];
	// shadow of the mode field, taken from bus writes
	always_ff @(posedge clk_i) begin
		if (rst_i)
			mode <= 4'h0;
		else if (take && adr_i == REG_CONTROL)
			mode <= dat_i[3:0];
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence pin_rise;
		$rose(event_pin_i);
	endsequence
	sequence cmp_hit;
		$rose(unit_event_flag_o);
	endsequence
	chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("no ack one cycle after request");
	chk_ctrl_read:
		assert property (ack_o && !we_i && adr_i == REG_CONTROL
			|-> dat_o[31:6] == 26'h0) else $error("control top bits set");
	chk_flag_sticky:
		assert property (unit_event_flag_o && !(take
			&& adr_i == REG_FLAGS && dat_i[FLAG_EVENT])
			|=> unit_event_flag_o)
		else $error("event flag dropped without write");
	chk_adc_special:
		assert property (adc_start_o |-> special_event_o &&
			mode == MODE_CMP_SPEC) else $error("adc start outside match");
	chk_special_flag:
		assert property ($rose(special_event_o) |=> unit_event_flag_o)
		else $error("special event without flag");
	chk_cap_rise:
		assert property (mode == MODE_CAP_RISE && $stable(mode) ##0 pin_rise
			|-> ##[2:5] unit_event_flag_o) else $error("rise not captured");
	chk_cmp_set:
		assert property (mode == MODE_CMP_SET ##0 cmp_hit
			|-> ##[0:3] event_pin_o) else $error("pin not set on match");
	chk_cmp_clr:
		assert property (mode == MODE_CMP_CLR ##0 cmp_hit
			|-> ##[0:3] !event_pin_o) else $error("pin not cleared on match");
	chk_sw_pin:
		assert property (mode == MODE_CMP_SW && $stable(mode)
			|=> event_pin_o == $past(port_data_i))
		else $error("pin not left to port");
endmodule
bind ccu_top ccu_monitor mon_u (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.event_pin_i(event_pin_i), .port_data_i(port_data_i),
	.event_pin_o(event_pin_o), .unit_event_flag_o(unit_event_flag_o),
	.special_event_o(special_event_o), .adc_start_o(adc_start_o));

//--- dv/ccu_pin_model.sv
`timescale 1ns/1ns
module ccu_pin_model (
	input  wire logic unit_out_i,
	input  wire logic unit_oe_i,
	input  wire logic ext_lvl_i,
	output logic      pin_o
);
	logic src = 1'b0;
	// outside source moves off the clock grid
	always @(ext_lvl_i) src <= #7 ext_lvl_i;
	// outside source lets go while the unit drives
	assign pin_o = unit_oe_i ? unit_out_i : src;
endmodule

//--- dv/capture_compare_unit_tb.sv
`timescale 1ns/1ns
module capture_compare_unit_tb import ccu_pkg::*;;
	logic        clk_i = 0;
	logic        rst_i = 1;
	logic        cyc = 0, stb = 0, we = 0, ext = 0, port = 0, dir = 1;
	logic [7:0]  adr = 0;
	logic [3:0]  sel = 4'hf;
	logic [31:0] wdat = 0, rd;
	wire  [31:0] dout;
	wire         ack, flag, spec, adc, upin, uoe, pin;
	int          miscompares = 0, check_count = 0, adc_n = 0, n0, n;
	int          spec_n = 0, s0;
	always #20 clk_i = ~clk_i;
	always @(posedge clk_i) if (adc) adc_n <= adc_n + 1;
	always @(posedge clk_i) if (spec) spec_n <= spec_n + 1;
	ccu_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dout),
		.ack_o(ack), .event_pin_i(pin), .port_data_i(port),
		.pin_direction_bit_i(dir), .pulse_tick_i(1'b1), .event_pin_o(upin),
		.event_pin_oe_o(uoe), .unit_event_flag_o(flag),
		.special_event_o(spec), .adc_start_o(adc));
	ccu_pin_model pin_u (.unit_out_i(upin), .unit_oe_i(uoe),
		.ext_lvl_i(ext), .pin_o(pin));
	// ----------------
	// bus and helpers
	// ----------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input int d);
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rd = dout;
		cyc <= 0;
		stb <= 0;
	endtask
	task automatic pulse;
		@(posedge clk_i);
		ext <= 1;
		repeat (6) @(posedge clk_i);
		ext <= 0;
		repeat (6) @(posedge clk_i);
	endtask
	task automatic t_regs;
		wb(0, REG_CONTROL, 0); chk(rd, 0);
		sel <= 4'h0;
		wb(1, REG_CONTROL, 'h3f);
		sel <= 4'hf;
		wb(0, REG_CONTROL, 0); chk(rd, 0);
		wb(1, REG_CONTROL, 'hff);
		wb(0, REG_CONTROL, 0); chk(rd, 'h3f);
		wb(1, 8'hfc, 'h55);
		wb(0, 8'hfc, 0); chk(rd, 0);
		for (int k = 1; k < 4; k++) begin
			wb(1, REG_CONTROL, k);
			wb(1, REG_FLAGS, 3);
			pulse;
			chk(flag, 0);
		end
	endtask
	task automatic t_capture;
		wb(1, REG_TB_CTRL, 0);
		wb(1, REG_TIMEBASE, 'h1234);
		wb(1, REG_CONTROL, MODE_CAP_RISE);
		wb(1, REG_FLAGS, 3);
		pulse;
		wb(0, REG_VALUE_LOW, 0); chk(rd, 'h34);
		wb(0, REG_VALUE_HIGH, 0); chk(rd, 'h12);
		wb(1, REG_TIMEBASE, 'habcd);
		@(posedge clk_i);
		ext <= 1;
		repeat (6) @(posedge clk_i);
		wb(1, REG_TIMEBASE, 'h5555);
		ext <= 0;
		repeat (6) @(posedge clk_i);
		wb(0, REG_VALUE_HIGH, 0); chk(rd, 'hab);
		chk(flag, 1);
		wb(1, REG_CONTROL, 0);
		wb(1, REG_CONTROL, MODE_CAP_FALL);
		wb(1, REG_FLAGS, 3);
		pulse;
		wb(0, REG_VALUE_LOW, 0); chk(rd, 'h55);
		wb(1, REG_CONTROL, MODE_CAP_RISE);
		wb(1, REG_FLAGS, 3);
		dir <= 0;
		repeat (4) @(posedge clk_i);
		chk(uoe, 1);
		port <= 1;
		repeat (6) @(posedge clk_i);
		chk(flag, 1);
		dir <= 1;
		port <= 0;
		repeat (2) @(posedge clk_i);
		chk(uoe, 0);
	endtask
	task automatic t_presc;
		for (int i = 0; i < 2; i++) begin
			wb(1, REG_CONTROL, i ? MODE_CAP_R16 : MODE_CAP_R4);
			repeat (2) pulse;
			wb(1, REG_CONTROL, 0);
			wb(1, REG_CONTROL, i ? MODE_CAP_R16 : MODE_CAP_R4);
			wb(1, REG_FLAGS, 3);
			repeat (i ? 15 : 3) pulse;
			chk(flag, 0);
			pulse;
			chk(flag, 1);
		end
	endtask
	task automatic t_compare;
		for (int k = 8; k < 12; k++) begin
			// mode 1001 keeps the set latch left by mode 1000
			if (k != 9)
				wb(1, REG_CONTROL, 0);
			wb(1, REG_TB_CTRL, 2);
			wb(1, REG_TIMEBASE, 'h0ff0);
			wb(1, REG_VALUE_LOW, 0);
			wb(1, REG_VALUE_HIGH, 'h10);
			port <= (k != 8);
			wb(1, REG_CONTROL, k);
			wb(1, REG_FLAGS, 3);
			chk(upin, k > 8);
			n0 = adc_n;
			s0 = spec_n;
			wb(1, REG_TB_CTRL, 3);
			n = 0;
			while (flag !== 1'b1 && n < 40) begin
				@(posedge clk_i);
				n++;
			end
			repeat (4) @(posedge clk_i);
			chk(upin, k != 9);
			chk(flag, 1);
			wb(1, REG_TB_CTRL, 2);
			wb(0, REG_TIMEBASE, 0); chk(rd < 'h10, k == 11);
			wb(0, REG_FLAGS, 0); chk(rd[1], 0);
			chk(adc_n - n0, k == 11);
			chk(spec_n - s0, k == 11);
		end
		port <= 0;
		wb(1, REG_CONTROL, 0);
		wb(1, REG_TIMEBASE, 'h1000);
		wb(1, REG_CONTROL, MODE_CMP_SET);
		repeat (3) @(posedge clk_i);
		chk(upin, 1);
		wb(1, REG_CONTROL, 0);
		wb(1, REG_TIMEBASE, 0);
		wb(1, REG_CONTROL, MODE_CMP_SET);
		repeat (3) @(posedge clk_i);
		chk(upin, 0);
		wb(1, REG_CONTROL, 'h0c);
		repeat (3) @(posedge clk_i);
		chk(upin, 0);
		wb(1, REG_CONTROL, 'h0f);
		repeat (3) @(posedge clk_i);
		chk(upin, 1);
		wb(1, REG_CONTROL, 0);
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		t_regs;
		t_capture;
		t_presc;
		t_compare;
		close_out;
	end
	initial begin
		repeat (8000) @(posedge clk_i);
		miscompares++;
		close_out;
	end
endmodule
